// ### hw/tswm_top.sv
/*
 Mode control of an automatic transfer switch controller: working modes, source
 availability timers, position orders with feedback supervision, generator contact.
 Assumes contact, button and source-status inputs are asynchronous pins and that
 analog measurement elsewhere reports per-source voltage, L1 frequency, rotation
 and neutral imbalance as logic levels.
*/
// Summary of operation
// - Three working modes: automatic, manual, inhibited; button or inhibit contact selects
// - Automatic mode orders positions from settings and ignores manual order buttons
// - Manual, no fault, no test on load, button held 3 s enters automatic, indicator on
// - Automatic, button held 3 s returns to manual, indicator off
// - Open inhibit contact blocks all orders but the fire order to position 0, blinks fault, automatic indicator off
// - Closing inhibit contact resumes the mode active before inhibition
// - Both sources present: rotation mismatch blinks both source indicators
// - Frequency judged on phase L1 only
// - Source lost only after fail timer of 0, 3, 10 or 30 minutes
// - Source back only after return timer of 3 s or 10 s
// - Three-phase network flags loss of neutral
// - Three one-hot order outputs for positions 0, I and II
// - Maintained style holds an order until a different order
// - Impulse style ends order after 5 s or on reached position
// - Impulse timeout raises fault and blocks automatic operation until cleared
// - Generator start on test on load or source 1 lost
// - Reaching position I while generator start is still on runs 180 s cooldown keeping generator started
// - Without auxiliary DC supply source 1 fail delay is skipped
// - Missing feedback after order blinks fault, sounds buzzer; feedback plus button clear
// - Fire input: fire indicator, buzzer, position 0, all control blocked
// - Fire removed: return to previous working mode
`timescale 1ns/100ps

module tswm_top
#(
   parameter int TICK_CYC = `TSWM_TICK_CYC
)
(
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   input  wire logic                 btn_mode,
   input  wire logic                 btn_pos0,
   input  wire logic                 btn_pos1,
   input  wire logic                 btn_pos2,
   input  wire logic                 inhibit_contact_input,
   input  wire logic                 fire_in,
   input  wire logic                 fb_pos0,
   input  wire logic                 fb_pos1,
   input  wire logic                 fb_pos2,
   input  wire logic                 aux_dc_present,
   input  wire logic                 test_on_load,
   input  wire logic [1:0]           src_volt_ok,
   input  wire logic [1:0]           src_freq_l1_ok,
   input  wire logic [1:0]           src_rot_fwd,
   input  wire logic [1:0]           src_neutral_imbal,
   input  wire logic [`TSWM_AW-1:0]  reg_addr,
   input  wire logic [`TSWM_DW-1:0]  reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [`TSWM_DW-1:0]  reg_rdata,
   output logic                      order_pos0,
   output logic                      order_pos1,
   output logic                      order_pos2,
   output logic                      gen_start_nc_closed,
   output logic                      gen_start_no_closed,
   output logic                      auto_mode_indicator,
   output logic                      fault_indicator,
   output logic                      fire_indicator,
   output logic      [1:0]           src_avail_indicator,
   output logic                      buzzer
);

   tswm_pkg::tswm_state_t state_reg;
   tswm_pkg::tswm_state_t state_next;

   logic [`TSWM_NIN-1:0] pins;
   logic [`TSWM_NIN-1:0] rise;
   logic                 tick;
   logic                 inhibit;
   logic                 fire;
   logic                 maint;
   logic [2:0]           fbv;
   logic                 reached;
   logic                 man_press;
   logic                 issue;
   logic                 raw_ok;
   logic [`TSWM_TM_W-1:0] fail_lim;
   logic [`TSWM_TM_W-1:0] lim;
   tswm_pkg::tswm_pos_t  req;
   tswm_pkg::tswm_pos_t  auto_des;

   assign pins = {src_neutral_imbal, src_rot_fwd, src_freq_l1_ok, src_volt_ok,
                  test_on_load, aux_dc_present, fb_pos2, fb_pos1, fb_pos0,
                  fire_in, inhibit_contact_input, btn_pos2, btn_pos1, btn_pos0,
                  btn_mode};
   assign rise    = state_reg.deb & ~state_reg.deb_q;
   assign tick    = (state_reg.pre == `TSWM_TICK_W'(TICK_CYC - 1));
   assign inhibit = ~state_reg.deb[`TSWM_IX_INH];
   assign fire    = state_reg.deb[`TSWM_IX_FIRE];
   assign maint   = state_reg.cfg[`TSWM_CFG_MAINT];
   assign fbv     = state_reg.deb[`TSWM_IX_FB2:`TSWM_IX_FB0];
   // Relies on the switch closing only the contact of its real position
   assign reached = (state_reg.ord_pos != tswm_pkg::TSWM_PNONE)
                    && fbv[state_reg.ord_pos];

   always_comb
   begin
      state_next = state_reg;
      req        = tswm_pkg::TSWM_PNONE;
      auto_des   = tswm_pkg::TSWM_PNONE;
      man_press  = 1'b0;
      issue      = 1'b0;
      raw_ok     = 1'b0;
      fail_lim   = '0;
      lim        = '0;

      // Prescaler, synchroniser and sampled debounce
      state_next.pre   = tick ? '0 : state_reg.pre + 1'b1;
      state_next.sync1 = pins;
      state_next.sync2 = state_reg.sync1;
      state_next.deb_q = state_reg.deb;
      if (tick)
      begin
         if (state_reg.dsub == 4'(`TSWM_DEB_TK - 1))
         begin
            state_next.dsub = '0;
            state_next.samp = state_reg.sync2;
            // Two agreeing samples 10 ms apart replace the level
            state_next.deb  = (state_reg.sync2 & state_reg.samp)
                              | (state_reg.deb & (state_reg.sync2 | state_reg.samp));
         end
         else
         begin
            state_next.dsub = state_reg.dsub + 1'b1;
         end
         if (state_reg.blk == 8'(`TSWM_BLINK_TK - 1))
         begin
            state_next.blk   = '0;
            state_next.blink = ~state_reg.blink;
         end
         else
         begin
            state_next.blk = state_reg.blk + 1'b1;
         end
      end

      // Source availability with fail and return delays
      for (int i = 0; i < 2; i++)
      begin
         state_next.neu_lost[i] = state_reg.cfg[`TSWM_CFG_3PH]
                                  & state_reg.deb[`TSWM_IX_NEU + i];
         raw_ok = state_reg.deb[`TSWM_IX_VOK + i]
                  & state_reg.deb[`TSWM_IX_FOK + i]
                  & ~state_next.neu_lost[i];
         case (state_reg.cfg[`TSWM_CFG_FAIL +: 2])
            2'h0:    fail_lim = `TSWM_TM_W'(`TSWM_FAIL_A_TK);
            2'h1:    fail_lim = `TSWM_TM_W'(`TSWM_FAIL_B_TK);
            2'h2:    fail_lim = `TSWM_TM_W'(`TSWM_FAIL_C_TK);
            default: fail_lim = `TSWM_TM_W'(`TSWM_FAIL_D_TK);
         endcase
         if (i == 0 && !state_reg.deb[`TSWM_IX_AUX])
         begin
            fail_lim = '0;
         end
         if (state_reg.avail[i])
         begin
            lim = fail_lim;
         end
         else if (state_reg.cfg[`TSWM_CFG_RET])
         begin
            lim = `TSWM_TM_W'(`TSWM_RET_B_TK);
         end
         else
         begin
            lim = `TSWM_TM_W'(`TSWM_RET_A_TK);
         end
         if (state_reg.avail[i] == raw_ok)
         begin
            state_next.stm[i] = '0;
         end
         else if (state_reg.stm[i] >= lim)
         begin
            // Condition held for the whole delay
            state_next.avail[i] = raw_ok;
            state_next.stm[i]   = '0;
         end
         else if (tick)
         begin
            state_next.stm[i] = state_reg.stm[i] + 1'b1;
         end
      end
      // One source alone is taken whatever its rotation
      state_next.rot_mis = (&state_reg.avail)
                           & (state_reg.deb[`TSWM_IX_ROT] ^ state_reg.deb[`TSWM_IX_ROT + 1]);

      // Mode button hold
      if (!state_reg.deb[`TSWM_IX_MODE])
      begin
         state_next.hold      = '0;
         state_next.hold_done = 1'b0;
      end
      else if (state_reg.hold == `TSWM_TM_W'(`TSWM_HOLD_TK))
      begin
         state_next.hold_done = 1'b1;
         // Mode kept under inhibit or fire so it can be resumed later
         if (!state_reg.hold_done && !inhibit && !fire)
         begin
            if (state_reg.mode == tswm_pkg::TSWM_MANUAL && !state_reg.fault
                && !state_reg.deb[`TSWM_IX_TEST])
            begin
               state_next.mode = tswm_pkg::TSWM_AUTO;
            end
            else if (state_reg.mode == tswm_pkg::TSWM_AUTO)
            begin
               state_next.mode = tswm_pkg::TSWM_MANUAL;
            end
         end
      end
      else if (tick)
      begin
         state_next.hold = state_reg.hold + 1'b1;
      end

      // Position request
      if (state_reg.deb[`TSWM_IX_TEST] && state_reg.avail[1])
      begin
         auto_des = tswm_pkg::TSWM_P2;
      end
      else if (state_reg.avail[0])
      begin
         auto_des = tswm_pkg::TSWM_P1;
      end
      else if (state_reg.avail[1])
      begin
         auto_des = tswm_pkg::TSWM_P2;
      end
      if (fire)
      begin
         req = tswm_pkg::TSWM_P0;
      end
      else if (inhibit)
      begin
         req = tswm_pkg::TSWM_PNONE;
      end
      else if (state_reg.mode == tswm_pkg::TSWM_AUTO)
      begin
         // Buttons ignored; a position fault stops the automatism
         if (!state_reg.fault)
         begin
            req = auto_des;
         end
      end
      else if (rise[`TSWM_IX_BP0])
      begin
         req       = tswm_pkg::TSWM_P0;
         man_press = 1'b1;
      end
      else if (rise[`TSWM_IX_BP1])
      begin
         req       = tswm_pkg::TSWM_P1;
         man_press = 1'b1;
      end
      else if (rise[`TSWM_IX_BP2])
      begin
         req       = tswm_pkg::TSWM_P2;
         man_press = 1'b1;
      end
      issue = (req != tswm_pkg::TSWM_PNONE) && (req != state_reg.ord_pos || man_press);

      // Fault clear: expected contact closed and button pressed
      if (state_reg.fault && reached && rise[`TSWM_IX_MODE])
      begin
         state_next.fault = 1'b0;
      end

      // Order supervision
      if (issue)
      begin
         state_next.ord_pos = req;
         state_next.ord_act = 1'b1;
         state_next.chk     = 1'b1;
         state_next.ord_tm  = '0;
      end
      else if (state_reg.chk)
      begin
         if (reached)
         begin
            state_next.chk     = 1'b0;
            state_next.ord_act = maint;
         end
         else if (tick && state_reg.ord_tm == `TSWM_TM_W'(`TSWM_ORD_TK - 1))
         begin
            // Set placed after the clear so a coincident timeout wins
            state_next.chk     = 1'b0;
            state_next.fault   = 1'b1;
            state_next.ord_act = maint;
         end
         else if (tick)
         begin
            state_next.ord_tm = state_reg.ord_tm + 1'b1;
         end
      end
      for (int p = 0; p < 3; p++)
      begin
         state_next.ord_out[p] = state_next.ord_act
                                 && (state_next.ord_pos == tswm_pkg::tswm_pos_t'(p));
      end

      // Generator contact and cooldown
      if (rise[`TSWM_IX_FB1] && state_reg.gen)
      begin
         state_next.cool = `TSWM_TM_W'(`TSWM_COOL_TK);
      end
      else if (tick && state_reg.cool != '0)
      begin
         state_next.cool = state_reg.cool - 1'b1;
      end
      state_next.gen    = state_reg.deb[`TSWM_IX_TEST] | ~state_reg.avail[0]
                          | (state_reg.cool != '0);
      state_next.gen_nc = state_reg.gen;
      state_next.gen_no = ~state_reg.gen;

      // Indicators
      state_next.led_auto  = (state_reg.mode == tswm_pkg::TSWM_AUTO)
                             & ~inhibit & ~fire;
      state_next.led_fault = (state_reg.fault | inhibit) & state_reg.blink;
      state_next.led_fire  = fire;
      state_next.buzzer    = fire | state_reg.fault;
      state_next.led_src   = state_reg.avail
                             & {2{~state_reg.rot_mis | state_reg.blink}};

      // Register port
      if (reg_wr && reg_addr == `TSWM_ADR_CFG)
      begin
         state_next.cfg = reg_wdata[`TSWM_CFG_W-1:0];
      end
      state_next.rdata = '0;
      if (reg_rd)
      begin
         case (reg_addr)
            `TSWM_ADR_CFG:  state_next.rdata = {3'h0, state_reg.cfg};
            `TSWM_ADR_STAT: state_next.rdata = {|state_reg.neu_lost, state_reg.rot_mis,
                                                state_reg.avail, state_reg.fault, fire,
                                                inhibit,
                                                state_reg.mode == tswm_pkg::TSWM_AUTO};
            `TSWM_ADR_POS:  state_next.rdata = {2'h0, fbv, state_reg.ord_act,
                                                state_reg.ord_pos};
            default:        state_next.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg         <= '0;
         state_reg.mode    <= tswm_pkg::TSWM_MANUAL;
         state_reg.ord_pos <= tswm_pkg::TSWM_PNONE;
         state_reg.cfg     <= `TSWM_CFG_RST;
         state_reg.sync1   <= `TSWM_NIN'h10;
         state_reg.sync2   <= `TSWM_NIN'h10;
         state_reg.samp    <= `TSWM_NIN'h10;
         state_reg.deb     <= `TSWM_NIN'h10;
         state_reg.deb_q   <= `TSWM_NIN'h10;
         state_reg.gen_no  <= 1'b1;
      end
      else
      begin
         // Mode register outlives inhibit and fire, so both resume it
         state_reg <= state_next;
      end
   end

   assign reg_rdata           = state_reg.rdata;
   assign order_pos0          = state_reg.ord_out[0];
   assign order_pos1          = state_reg.ord_out[1];
   assign order_pos2          = state_reg.ord_out[2];
   assign gen_start_nc_closed = state_reg.gen_nc;
   assign gen_start_no_closed = state_reg.gen_no;
   assign auto_mode_indicator = state_reg.led_auto;
   assign fault_indicator     = state_reg.led_fault;
   assign fire_indicator      = state_reg.led_fire;
   assign src_avail_indicator = state_reg.led_src;
   assign buzzer              = state_reg.buzzer;

endmodule // tswm_top

// ### hw/tswm_map.svh
/*
 Constants of the transfer switch mode control: bit positions, register offsets and
 field layouts, reset values and timer figures. Assumes a 125 MHz system clock.
*/
`ifndef TSWM_MAP_SVH
`define TSWM_MAP_SVH

// Clock and timer base
`define TSWM_CLK_HZ      125000000
`define TSWM_TICK_US     1000
`define TSWM_TICK_CYC    (`TSWM_CLK_HZ / 1000000 * `TSWM_TICK_US)
`define TSWM_TICK_W      17
`define TSWM_TM_W        21

// Times in their own units, then in 1 ms ticks
`define TSWM_DEB_MS      10
`define TSWM_BLINK_MS    250
`define TSWM_HOLD_S      3
`define TSWM_ORD_S       5
`define TSWM_COOL_S      180
`define TSWM_RET_A_S     3
`define TSWM_RET_B_S     10
`define TSWM_FAIL_A_MIN  0
`define TSWM_FAIL_B_MIN  3
`define TSWM_FAIL_C_MIN  10
`define TSWM_FAIL_D_MIN  30
`define TSWM_DEB_TK      (`TSWM_DEB_MS * 1000 / `TSWM_TICK_US)
`define TSWM_BLINK_TK    (`TSWM_BLINK_MS * 1000 / `TSWM_TICK_US)
`define TSWM_HOLD_TK     (`TSWM_HOLD_S * 1000000 / `TSWM_TICK_US)
`define TSWM_ORD_TK      (`TSWM_ORD_S * 1000000 / `TSWM_TICK_US)
`define TSWM_COOL_TK     (`TSWM_COOL_S * 1000000 / `TSWM_TICK_US)
`define TSWM_RET_A_TK    (`TSWM_RET_A_S * 1000000 / `TSWM_TICK_US)
`define TSWM_RET_B_TK    (`TSWM_RET_B_S * 1000000 / `TSWM_TICK_US)
`define TSWM_FAIL_A_TK   (`TSWM_FAIL_A_MIN * 60000000 / `TSWM_TICK_US)
`define TSWM_FAIL_B_TK   (`TSWM_FAIL_B_MIN * 60000000 / `TSWM_TICK_US)
`define TSWM_FAIL_C_TK   (`TSWM_FAIL_C_MIN * 60000000 / `TSWM_TICK_US)
`define TSWM_FAIL_D_TK   (`TSWM_FAIL_D_MIN * 60000000 / `TSWM_TICK_US)

// Synchronised input vector positions
`define TSWM_NIN         19
`define TSWM_IX_MODE     0
`define TSWM_IX_BP0      1
`define TSWM_IX_BP1      2
`define TSWM_IX_BP2      3
`define TSWM_IX_INH      4
`define TSWM_IX_FIRE     5
`define TSWM_IX_FB0      6
`define TSWM_IX_FB1      7
`define TSWM_IX_FB2      8
`define TSWM_IX_AUX      9
`define TSWM_IX_TEST     10
`define TSWM_IX_VOK      11
`define TSWM_IX_FOK      13
`define TSWM_IX_ROT      15
`define TSWM_IX_NEU      17

// Register port
`define TSWM_AW          2
`define TSWM_DW          8
`define TSWM_ADR_CFG     2'h0
`define TSWM_ADR_STAT    2'h1
`define TSWM_ADR_POS     2'h2
`define TSWM_CFG_W       5
`define TSWM_CFG_RST     5'h00
`define TSWM_CFG_MAINT   0
`define TSWM_CFG_FAIL    1
`define TSWM_CFG_RET     3
`define TSWM_CFG_3PH     4

`endif

// ### hw/tswm_pkg.sv
/*
 Types of the transfer switch mode control: modes, positions and the state record.
 Assumes tswm_map.svh is on the include path.
*/
`include "tswm_map.svh"

package tswm_pkg;

   typedef enum logic {TSWM_MANUAL, TSWM_AUTO} tswm_mode_t;

   typedef enum logic [1:0] {TSWM_P0, TSWM_P1, TSWM_P2, TSWM_PNONE} tswm_pos_t;

   typedef struct packed {
      logic [`TSWM_TICK_W-1:0]      pre;
      logic [3:0]                   dsub;
      logic [7:0]                   blk;
      logic                         blink;
      logic [`TSWM_NIN-1:0]         sync1;
      logic [`TSWM_NIN-1:0]         sync2;
      logic [`TSWM_NIN-1:0]         samp;
      logic [`TSWM_NIN-1:0]         deb;
      logic [`TSWM_NIN-1:0]         deb_q;
      tswm_mode_t                   mode;
      logic [`TSWM_TM_W-1:0]        hold;
      logic                         hold_done;
      logic [1:0]                   avail;
      logic [1:0][`TSWM_TM_W-1:0]   stm;
      logic [1:0]                   neu_lost;
      logic                         rot_mis;
      tswm_pos_t                    ord_pos;
      logic                         ord_act;
      logic                         chk;
      logic [`TSWM_TM_W-1:0]        ord_tm;
      logic                         fault;
      logic [`TSWM_TM_W-1:0]        cool;
      logic                         gen;
      logic [`TSWM_CFG_W-1:0]       cfg;
      logic [`TSWM_DW-1:0]          rdata;
      logic [2:0]                   ord_out;
      logic                         gen_nc;
      logic                         gen_no;
      logic                         led_auto;
      logic                         led_fault;
      logic                         led_fire;
      logic [1:0]                   led_src;
      logic                         buzzer;
   } tswm_state_t;

endpackage

// ### verification/tswm_checker.sv
/*
 Port assertions for the transfer switch mode control.
 Assumes binding into tswm_top, sharing its TICK_CYC.
*/
`timescale 1ns/100ps

module tswm_checker
#(
   parameter int TICK_CYC = 10
)
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic btn_mode,
   input wire logic inhibit_contact_input,
   input wire logic fire_in,
   input wire logic order_pos0,
   input wire logic order_pos1,
   input wire logic order_pos2,
   input wire logic gen_start_nc_closed,
   input wire logic gen_start_no_closed,
   input wire logic auto_mode_indicator,
   input wire logic fault_indicator,
   input wire logic fire_indicator,
   input wire logic buzzer
);
   int c_inh, c_fire, c_btn, c_flt, c_calm;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   // Raw pin ages; 30 ticks of slack cover sync plus two debounce samples
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         {c_inh, c_fire, c_btn, c_flt, c_calm} <= '0;
      else
      begin
         c_inh  <= inhibit_contact_input ? 0 : c_inh + 1;
         c_fire <= fire_in ? c_fire + 1 : 0;
         c_btn  <= btn_mode ? c_btn + 1 : 0;
         c_flt  <= fault_indicator ? c_flt + 1 : 0;
         c_calm <= (fire_in || !inhibit_contact_input) ? 0 : c_calm + 1;
      end
   end

   a_order_onehot: assert property ($onehot0({order_pos2, order_pos1, order_pos0}))
      else $error("order outputs not one-hot");
   a_gen_pair: assert property (gen_start_nc_closed != gen_start_no_closed)
      else $error("generator contacts not complementary");
   a_fire_forces_zero: assert property (c_fire > 30 * TICK_CYC |-> fire_indicator && buzzer && !order_pos1 && !order_pos2)
      else $error("fire not handled");
   a_fire_led_buzz: assert property (fire_indicator |-> buzzer)
      else $error("fire indicator without buzzer");
   a_inhibit_auto_off: assert property (c_inh > 30 * TICK_CYC |-> !auto_mode_indicator)
      else $error("auto indicator lit while inhibited");
   a_inhibit_no_order: assert property (c_inh > 30 * TICK_CYC |-> !$rose(order_pos0 | order_pos1 | order_pos2))
      else $error("new order while inhibited");
   a_mode_hold_time: assert property ($rose(auto_mode_indicator) && c_calm > 30 * TICK_CYC |-> c_btn >= 2990 * TICK_CYC)
      else $error("auto mode entered without 3 s hold");
   a_fault_blinks: assert property (c_flt <= 251 * TICK_CYC)
      else $error("fault indicator steady instead of blinking");
endmodule // tswm_checker

bind tswm_top tswm_checker #(.TICK_CYC(TICK_CYC)) u_chk (.*);

// ### verification/tswm_switch_model.sv
/*
 Behavioural motorised transfer switch with position contacts.
 Assumes the three order outputs of the mode control drive it.
*/
`timescale 1ns/100ps

module tswm_switch_model
#(
   parameter int DLY = 500
)
(
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic order_pos0,
   input  wire logic order_pos1,
   input  wire logic order_pos2,
   input  wire logic stuck,
   output logic      fb_pos0,
   output logic      fb_pos1,
   output logic      fb_pos2
);
   logic [1:0] pos;
   logic [1:0] goal;
   int         cnt;

   assign goal = order_pos2 ? 2'h2 : (order_pos1 ? 2'h1 : 2'h0);
   assign {fb_pos2, fb_pos1, fb_pos0} = 3'h1 << pos;

   // Travel needs a held order; a jammed mechanism never arrives
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         pos <= 2'h0;
      else if (stuck || !(order_pos0 || order_pos1 || order_pos2) || goal == pos)
         cnt <= 0;
      else if (cnt == DLY)
         pos <= goal;
      else
         cnt <= cnt + 1;
   end
endmodule // tswm_switch_model

// ### verification/tb_transfer_switch_mode_control.sv
/*
 Self-checking bench for the transfer switch mode control.
 Assumes tswm_map.svh on the include path and the switch model beside it.
*/
`timescale 1ns/100ps
`include "tswm_map.svh"

module tb_transfer_switch_mode_control;
   localparam int TICK = 10;
   logic clk_sys = 1'b0, rst_b = 1'b0, btn_mode = 1'b0, fire_in = 1'b0, stuck = 1'b0;
   logic btn_pos0 = 1'b0, btn_pos1 = 1'b0, btn_pos2 = 1'b0, inhibit_contact_input = 1'b1;
   logic aux_dc_present = 1'b0, test_on_load = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [1:0] src_volt_ok = 2'h3, src_freq_l1_ok = 2'h3, src_rot_fwd = 2'h0;
   logic [1:0] src_neutral_imbal = 2'h0, reg_addr = 2'h0, src_avail_indicator;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic fb_pos0, fb_pos1, fb_pos2, order_pos0, order_pos1, order_pos2, buzzer;
   logic gen_start_nc_closed, gen_start_no_closed, auto_mode_indicator;
   logic fault_indicator, fire_indicator;
   int   fails = 0;
   int   samples_checked = 0;

   always #4 clk_sys = ~clk_sys;
   tswm_top #(.TICK_CYC(TICK)) dut (.*);
   tswm_switch_model #(.DLY(500)) u_sw (.*);

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk("reg_rdata", exp, reg_rdata);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      idle(1);
      chk("auto_led", 8'h00, 8'(auto_mode_indicator));
      reg_write(2'h0, 8'hFF);
      reg_read(2'h0, 8'h1F);
      reg_write(2'h3, 8'h00);
      reg_read(2'h0, 8'h1F);
      reg_read(2'h3, 8'h00);
      reg_write(2'h0, 8'h03);
      @(posedge clk_sys) btn_pos1 <= 1'b1;
      for (int i = 0; i < 2000 && order_pos1 !== 1'b1; i++) @(negedge clk_sys);
      chk("order_pos1", 8'h01, 8'(order_pos1));
      chk("order_other", 8'h00, 8'(order_pos0 | order_pos2));
      @(posedge clk_sys) btn_pos1 <= 1'b0;
      idle(1200);
      chk("fb_pos1", 8'h01, 8'(fb_pos1));
      chk("order_pos1", 8'h01, 8'(order_pos1));
      chk("buzzer", 8'h00, 8'(buzzer));
      reg_write(2'h0, 8'h02);
      @(posedge clk_sys) inhibit_contact_input <= 1'b0;
      idle(400);
      @(posedge clk_sys) btn_pos2 <= 1'b1;
      idle(600);
      chk("order_pos2", 8'h00, 8'(order_pos2));
      @(posedge clk_sys) btn_pos2 <= 1'b0;
      @(posedge clk_sys) inhibit_contact_input <= 1'b1;
      idle(400);
      @(posedge clk_sys) btn_mode <= 1'b1;
      idle(3050 * TICK);
      chk("auto_led", 8'h01, 8'(auto_mode_indicator));
      chk("src_led", 8'h03, 8'(src_avail_indicator));
      @(posedge clk_sys) btn_mode <= 1'b0;
      @(posedge clk_sys) btn_pos2 <= 1'b1;
      idle(600);
      chk("order_pos2", 8'h00, 8'(order_pos2));
      @(posedge clk_sys) btn_pos2 <= 1'b0;
      @(posedge clk_sys) fire_in <= 1'b1;
      idle(400);
      chk("fire_led", 8'h01, 8'(fire_indicator));
      chk("buzzer", 8'h01, 8'(buzzer));
      chk("order_pos0", 8'h01, 8'(order_pos0));
      idle(1000);
      @(posedge clk_sys) fire_in <= 1'b0;
      for (int i = 0; i < 2000 && order_pos1 !== 1'b1; i++) @(negedge clk_sys);
      chk("order_pos1", 8'h01, 8'(order_pos1));
      chk("auto_led", 8'h01, 8'(auto_mode_indicator));
      idle(1500);
      chk("order_pos1", 8'h00, 8'(order_pos1));
      @(posedge clk_sys) stuck <= 1'b1;
      @(posedge clk_sys) src_volt_ok <= 2'h2;
      idle(400);
      chk("gen_start", 8'h01, 8'(gen_start_nc_closed));
      reg_read(2'h1, 8'h21);
      chk("src_led", 8'h02, 8'(src_avail_indicator));
      chk("order_pos2", 8'h01, 8'(order_pos2));
      for (int i = 0; i < 5200 * TICK && buzzer !== 1'b1; i++) @(negedge clk_sys);
      chk("buzzer", 8'h01, 8'(buzzer));
      chk("order_pos2", 8'h00, 8'(order_pos2));
      tally_and_finish();
   end

   initial
   begin
      repeat (99000) @(posedge clk_sys);
      fails++;
      tally_and_finish();
   end
endmodule // tb_transfer_switch_mode_control
